// >>> bench/watchdog_with_option_latches_test.sv
`timescale 1ns/100ps
`include "wdol_regs.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module watchdog_with_option_latches_test;
    logic REF_CLK_IN, RST_IN, HSEL_IN, HWRITE_IN, HREADYOUT_OUT, HRESP_OUT;
    logic [31:0] HADDR_IN, HWDATA_IN, HRDATA_OUT, rd;
    logic [1:0]  HTRANS_IN;
    logic [2:0]  HSIZE_IN;
    logic STOP_EXEC_IN, WAKE_IN, PIN_WAKE_IN, VEC_FETCH_IN, EXT_RST_IN;
    logic MONITOR_IN, BREAK_IN, HV_RST_IN, HV_IRQ_IN, SUPV_RST_REQ_IN;
    logic SUPV_POWER_OUT, SUPV_ACTIVE_OUT, SUPV_MODE5_OUT, OSC_RUN_OUT;
    logic SERIAL_CLK_SEL_OUT, STOP_MODE_OUT, CPU_HOLD_OUT, SYS_RST_OUT;
    logic RST_PIN_OUT, RST_PIN_OE_N_OUT, hang;
    int   error_cnt, n_checks, n;
    wdol_top #(.RESET_VEC_LO(8'h5c)) u_wdol_top (
        .REF_CLK_IN, .RST_IN, .HSEL_IN, .HADDR_IN, .HTRANS_IN, .HWRITE_IN,
        .HSIZE_IN, .HWDATA_IN, .HREADY_IN(HREADYOUT_OUT), .HREADYOUT_OUT,
        .HRDATA_OUT, .HRESP_OUT, .STOP_EXEC_IN, .WAKE_IN, .PIN_WAKE_IN,
        .VEC_FETCH_IN, .EXT_RST_IN, .MONITOR_IN, .BREAK_IN, .HV_RST_IN,
        .HV_IRQ_IN, .SUPV_RST_REQ_IN, .SUPV_POWER_OUT, .SUPV_ACTIVE_OUT,
        .SUPV_MODE5_OUT, .OSC_RUN_OUT, .SERIAL_CLK_SEL_OUT, .STOP_MODE_OUT,
        .CPU_HOLD_OUT, .SYS_RST_OUT, .RST_PIN_OUT, .RST_PIN_OE_N_OUT);
    wdol_core_model u_wdol_core_model (
        .clk_in(REF_CLK_IN), .hready_in(HREADYOUT_OUT),
        .hrdata_in(HRDATA_OUT), .hsel_out(HSEL_IN), .haddr_out(HADDR_IN),
        .htrans_out(HTRANS_IN), .hwrite_out(HWRITE_IN),
        .hsize_out(HSIZE_IN), .hwdata_out(HWDATA_IN));
    // ------------------------------
    // shared tasks
    // ------------------------------
    task give_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // a spent wait bound counts as a mismatch and ends the run
    task automatic tmo(input bit t);
        if (t) begin
            error_cnt++;
            give_verdict();
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] i,
                       input logic [31:0] d);
        u_wdol_core_model.xfer(w, i, d, rd, hang);
        tmo(hang);
    endtask
    task automatic rd_chk(input logic [15:0] i, input logic [31:0] e);
        bus(1'b0, i, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge REF_CLK_IN);
    endtask
    // 0 stop, 1 wake, 2 pin wake, else vector fetch
    task automatic pulse(input int s);
        case (s)
            0: STOP_EXEC_IN <= 1'b1;
            1: WAKE_IN <= 1'b1;
            2: PIN_WAKE_IN <= 1'b1;
            default: VEC_FETCH_IN <= 1'b1;
        endcase
        @(posedge REF_CLK_IN);
        {STOP_EXEC_IN, WAKE_IN, PIN_WAKE_IN, VEC_FETCH_IN} <= 4'h0;
    endtask
    // count recovery cycles after a wake source, stop must be enabled
    task automatic stop_exit(input int w, input int e);
        logic c;
        int   k;
        n = 0;
        k = 0;
        pulse(0);
        cyc(1);
        `CHK(STOP_MODE_OUT, 1'b1)
        // oscillator stop enable was set, so it keeps running
        `CHK(OSC_RUN_OUT, 1'b1)
        pulse(w);
        do begin
            @(posedge REF_CLK_IN);
            c = CPU_HOLD_OUT;
            if (c && !STOP_MODE_OUT) n++;
            k++;
        end while (c !== 1'b0 && k < 5000);
        tmo(c !== 1'b0);
        `CHK(n, e)
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_reset;
        rd_chk(`WDOL_IDX_OPT1, 32'h0);
        rd_chk(`WDOL_IDX_OPT2, 32'h0);
        rd_chk(`WDOL_IDX_SVC, 32'h5c);
        rd_chk(16'h0040, 32'h0);
    endtask
    task automatic t_opts;
        bus(1'b1, `WDOL_IDX_OPT2, 32'h3);
        bus(1'b1, `WDOL_IDX_OPT2, 32'h0);
        rd_chk(`WDOL_IDX_OPT2, 32'h3);
        `CHK(SERIAL_CLK_SEL_OUT, 1'b1)
        bus(1'b1, `WDOL_IDX_OPT1, 32'h9e);
        bus(1'b1, `WDOL_IDX_OPT1, 32'h0);
        rd_chk(`WDOL_IDX_OPT1, 32'h9e);
        `CHK(SUPV_POWER_OUT, 1'b0)
        `CHK(SUPV_ACTIVE_OUT, 1'b0)
        `CHK(SUPV_MODE5_OUT, 1'b1)
    endtask
    task automatic t_stop;
        bus(1'b1, `WDOL_IDX_SVC, 32'ha5);
        stop_exit(1, 32);
        stop_exit(2, 4096);
    endtask
    task automatic t_wdog;
        logic lo;
        bus(1'b1, `WDOL_IDX_SVC, 32'h0);
        repeat (3) begin
            cyc(4000);
            pulse(3);
            bus(1'b1, `WDOL_IDX_SVC, 32'h0);
            `CHK(RST_PIN_OE_N_OUT, 1'b1)
        end
        n = 0;
        do begin
            @(posedge REF_CLK_IN);
            n++;
        end while (RST_PIN_OE_N_OUT === 1'b1 && n < 9000);
        tmo(n >= 9000);
        `CHK(n >= 8155 && n <= 8180, 1'b1)
        n = 1;
        do begin
            @(posedge REF_CLK_IN);
            lo = !RST_PIN_OE_N_OUT;
            if (lo) n++;
        end while (lo && n < 100);
        tmo(lo);
        `CHK(n, 32)
        bus(1'b0, `WDOL_IDX_STAT, 32'h0);
        `CHK(rd[`WDOL_ST_WD_FLAG], 1'b1)
        rd_chk(`WDOL_IDX_OPT1, 32'h08);
        bus(1'b1, `WDOL_IDX_OPT1, 32'h01);
        rd_chk(`WDOL_IDX_OPT1, 32'h09);
        cyc(9000);
        bus(1'b0, `WDOL_IDX_STAT, 32'h0);
        `CHK(rd[13:8], 6'h00)
        `CHK(RST_PIN_OE_N_OUT, 1'b1)
    endtask
    task automatic t_internal;
        EXT_RST_IN <= 1'b1;
        @(posedge REF_CLK_IN);
        `CHK(SYS_RST_OUT, 1'b1)
        EXT_RST_IN <= 1'b0;
        rd_chk(`WDOL_IDX_OPT1, 32'h08);
        pulse(STOP_EXEC_IN);
        cyc(1);
        `CHK(SYS_RST_OUT, 1'b1)
        `CHK(STOP_MODE_OUT, 1'b0)
        SUPV_RST_REQ_IN <= 1'b1;
        @(posedge REF_CLK_IN);
        `CHK(SYS_RST_OUT, 1'b1)
        SUPV_RST_REQ_IN <= 1'b0;
        bus(1'b1, `WDOL_IDX_OPT1, 32'h20);
        SUPV_RST_REQ_IN <= 1'b1;
        @(posedge REF_CLK_IN);
        `CHK(SYS_RST_OUT, 1'b0)
        SUPV_RST_REQ_IN <= 1'b0;
        // a running watchdog would show counter 1 after this wait
        MONITOR_IN <= 1'b1;
        HV_IRQ_IN  <= 1'b1;
        cyc(4200);
        bus(1'b0, `WDOL_IDX_STAT, 32'h0);
        `CHK(rd[13:8], 6'h00)
        MONITOR_IN <= 1'b0;
        HV_IRQ_IN  <= 1'b0;
    endtask
    initial begin
        REF_CLK_IN = 1'b0;
        forever #50 REF_CLK_IN = ~REF_CLK_IN;
    end
    initial begin
        {STOP_EXEC_IN, WAKE_IN, PIN_WAKE_IN, VEC_FETCH_IN} = 4'h0;
        {EXT_RST_IN, MONITOR_IN, BREAK_IN, HV_RST_IN} = 4'h0;
        {HV_IRQ_IN, SUPV_RST_REQ_IN} = 2'h0;
        error_cnt = 0;
        n_checks = 0;
        RST_IN = 1'b1;
        repeat (10) @(posedge REF_CLK_IN);
        RST_IN <= 1'b0;
        t_reset();
        t_opts();
        t_stop();
        t_wdog();
        t_internal();
        give_verdict();
    end
endmodule // watchdog_with_option_latches_test

// >>> bench/wdol_core_model.sv
`timescale 1ns/100ps
module wdol_core_model (
    // bus clock and answer
    input wire logic        clk_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_in,
    // bus request
    output logic            hsel_out,
    output logic [31:0]     haddr_out,
    output logic [1:0]      htrans_out,
    output logic            hwrite_out,
    output logic [2:0]      hsize_out,
    output logic [31:0]     hwdata_out
);
    initial begin
        hsel_out   = 1'b0;
        haddr_out  = 32'h0;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out  = 3'h2;
        hwdata_out = 32'h0;
    end
    // ------------------------------
    // single word transfer, called just after an edge
    // ------------------------------
    task automatic xfer(input logic w, input logic [15:0] idx,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic hang);
        int n;
        n = 0;
        hsel_out   <= 1'b1;
        haddr_out  <= {14'h0, idx, 2'b00};
        htrans_out <= 2'h2;
        hwrite_out <= w;
        do begin
            @(posedge clk_in);
            n++;
        end while (hready_in !== 1'b1 && n < 64);
        hsel_out   <= 1'b0;
        htrans_out <= 2'h0;
        hwdata_out <= d;
        do begin
            @(posedge clk_in);
            n++;
        end while (hready_in !== 1'b1 && n < 128);
        r = hrdata_in;
        hang = (hready_in !== 1'b1);
    endtask
endmodule // wdol_core_model

// >>> bench/wdol_top_monitor.sv
`timescale 1ns/100ps
module wdol_top_monitor (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    // watched ports
    input wire logic HREADYOUT_OUT,
    input wire logic HRESP_OUT,
    input wire logic STOP_EXEC_IN,
    input wire logic EXT_RST_IN,
    input wire logic SUPV_POWER_OUT,
    input wire logic SUPV_ACTIVE_OUT,
    input wire logic OSC_RUN_OUT,
    input wire logic STOP_MODE_OUT,
    input wire logic CPU_HOLD_OUT,
    input wire logic SYS_RST_OUT,
    input wire logic RST_PIN_OUT,
    input wire logic RST_PIN_OE_N_OUT
);
    logic [5:0]  lo_cnt_ff;
    logic [12:0] hold_cnt_ff;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);
    // ------------------------------
    // pulse and recovery length counters
    // ------------------------------
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            lo_cnt_ff   <= 6'h00;
            hold_cnt_ff <= 13'h0000;
        end else begin
            lo_cnt_ff   <= RST_PIN_OE_N_OUT ? 6'h00 : lo_cnt_ff + 6'h01;
            hold_cnt_ff <= (CPU_HOLD_OUT && !STOP_MODE_OUT) ?
                           hold_cnt_ff + 13'h0001 : 13'h0000;
        end
    end
    property p_bus_okay;
        HREADYOUT_OUT && !HRESP_OUT;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus slave not ready or not okay");
    property p_pin_len;
        $rose(RST_PIN_OE_N_OUT) |-> lo_cnt_ff == 6'h20;
    endproperty
    a_pin_len: assert property (p_pin_len)
        else $error("reset pin pulse length wrong");
    property p_pin_sys;
        !RST_PIN_OE_N_OUT |-> SYS_RST_OUT && !RST_PIN_OUT;
    endproperty
    a_pin_sys: assert property (p_pin_sys)
        else $error("pin driven without system reset");
    property p_stop;
        STOP_EXEC_IN && !CPU_HOLD_OUT && !SYS_RST_OUT
            |=> STOP_MODE_OUT != SYS_RST_OUT;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop neither entered nor refused");
    property p_osc;
        !STOP_MODE_OUT |-> OSC_RUN_OUT;
    endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator off outside stop");
    property p_supv;
        !SUPV_POWER_OUT |-> !SUPV_ACTIVE_OUT;
    endproperty
    a_supv: assert property (p_supv)
        else $error("supervisor active while powered down");
    property p_ext;
        EXT_RST_IN |-> ##[0:1] SYS_RST_OUT;
    endproperty
    a_ext: assert property (p_ext)
        else $error("internal reset not passed on");
    property p_hold;
        $fell(CPU_HOLD_OUT) |->
            hold_cnt_ff == 13'h0020 || hold_cnt_ff == 13'h1000;
    endproperty
    a_hold: assert property (p_hold)
        else $error("stop recovery length wrong");
endmodule // wdol_top_monitor

bind wdol_top wdol_top_monitor u_wdol_top_monitor (
    .REF_CLK_IN, .RST_IN, .HREADYOUT_OUT, .HRESP_OUT, .STOP_EXEC_IN,
    .EXT_RST_IN, .SUPV_POWER_OUT, .SUPV_ACTIVE_OUT, .OSC_RUN_OUT,
    .STOP_MODE_OUT, .CPU_HOLD_OUT, .SYS_RST_OUT, .RST_PIN_OUT,
    .RST_PIN_OE_N_OUT
);

// >>> core/wdol_optlatch.v
`timescale 1ns/100ps
`include "wdol_regs.vh"

module wdol_optlatch (
    // clock and resets
    input  wire       clk_in,
    input  wire       por_in,
    input  wire       clr_in,
    // write port
    input  wire       wr_in,
    input  wire [7:0] wdata_in,
    input  wire [7:0] keep_in,
    // latched options
    output wire [7:0] q_out
);

reg  [7:0] val_ff;
reg        done_ff;
reg        kdone_ff;
wire [7:0] nxt_val;

// keep bits have their own write-once flag, cleared by power-on only
assign nxt_val = ((done_ff ? val_ff : wdata_in) & ~keep_in) |
                 ((kdone_ff ? val_ff : wdata_in) & keep_in);

always @(posedge clk_in or posedge por_in) begin
    if (por_in) begin
        val_ff   <= `WDOL_OPT_RESET;
        done_ff  <= 1'b0;
        kdone_ff <= 1'b0;
    end else if (clr_in) begin
        val_ff  <= val_ff & keep_in;
        done_ff <= 1'b0;
    end else if (wr_in) begin
        val_ff   <= nxt_val;
        done_ff  <= 1'b1;
        kdone_ff <= 1'b1;
    end
end

assign q_out = val_ff;

endmodule // wdol_optlatch

// >>> core/wdol_top.v
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/100ps
`include "wdol_regs.vh"

// Overview of operation
// - each option register takes one write per reset
// - reset clears options except supervisor mode select
// - supervisor mode select: power-on reset, write once
// - options at 0x1e/0x1f, reads side-effect free
// - oscillator kept running in stop when enabled
// - baud clock select: bus clock or oscillator
// - rate select picks short or long timeout
// - supervisor stop enable keeps it running stopped
// - reset disable blocks supervisor reset requests
// - power disable switches supervisor off
// - mode select picks 5V or 3V supervisor
// - short recovery 32, otherwise 4096 cycles
// - reset-pin stop exit always uses long recovery
// - stop disabled means stop is illegal opcode
// - watchdog disable bit turns the watchdog off
// - 6-bit counter after 12-bit prescaler, overflow resets
// - service write clears counter and upper prescaler
// - service read returns reset vector low byte
// - watchdog reset: pin low 32 cycles, flag set
// - stop instruction clears the prescaler
// - prescaler cleared 4096 cycles after power-up
// - internal reset clears all; vector fetch prescaler
// - test voltage in monitor or break disables
// - stop mode freezes the watchdog
// - disabled stop instruction causes illegal reset
module wdol_top #(
    // arbitrary default, strap to the real vector
    parameter [7:0] RESET_VEC_LO = 8'h00
) (
    // clock and power-on reset
    input  wire        REF_CLK_IN,
    input  wire        RST_IN,
    // ahb-lite slave
    input  wire        HSEL_IN,
    input  wire [31:0] HADDR_IN,
    input  wire [1:0]  HTRANS_IN,
    input  wire        HWRITE_IN,
    input  wire [2:0]  HSIZE_IN,
    input  wire [31:0] HWDATA_IN,
    input  wire        HREADY_IN,
    output wire        HREADYOUT_OUT,
    output wire [31:0] HRDATA_OUT,
    output wire        HRESP_OUT,
    // core events
    input  wire        STOP_EXEC_IN,
    input  wire        WAKE_IN,
    input  wire        PIN_WAKE_IN,
    input  wire        VEC_FETCH_IN,
    input  wire        EXT_RST_IN,
    // test and debug state
    input  wire        MONITOR_IN,
    input  wire        BREAK_IN,
    input  wire        HV_RST_IN,
    input  wire        HV_IRQ_IN,
    // supervisor
    input  wire        SUPV_RST_REQ_IN,
    output wire        SUPV_POWER_OUT,
    output wire        SUPV_ACTIVE_OUT,
    output wire        SUPV_MODE5_OUT,
    // clocking and low power
    output wire        OSC_RUN_OUT,
    output wire        SERIAL_CLK_SEL_OUT,
    output wire        STOP_MODE_OUT,
    output wire        CPU_HOLD_OUT,
    // system reset and reset pin
    output wire        SYS_RST_OUT,
    output wire        RST_PIN_OUT,
    output wire        RST_PIN_OE_N_OUT
);

// ------------------------------------------------
// stop-mode states
// ------------------------------------------------
localparam [1:0] ST_RUN  = 2'b00;
localparam [1:0] ST_STOP = 2'b01;
localparam [1:0] ST_REC  = 2'b10;

// ------------------------------------------------
// address decode
// ------------------------------------------------
function [2:0] reg_sel;
    input [31:0] addr;
    reg   [15:0] idx;
    begin
        idx = addr[17:2];
        if (addr[31:18] != 14'h0000 || addr[1:0] != 2'b00) begin
            reg_sel = `WDOL_SEL_NONE;
        end else if (idx == `WDOL_IDX_OPT2) begin
            reg_sel = `WDOL_SEL_OPT2;
        end else if (idx == `WDOL_IDX_OPT1) begin
            reg_sel = `WDOL_SEL_OPT1;
        end else if (idx == `WDOL_IDX_STAT) begin
            reg_sel = `WDOL_SEL_STAT;
        end else if (idx == `WDOL_IDX_SVC) begin
            reg_sel = `WDOL_SEL_SVC;
        end else begin
            reg_sel = `WDOL_SEL_NONE;
        end
    end
endfunction

// ------------------------------------------------
// declarations
// ------------------------------------------------
reg  [1:0]  state_ff;
reg  [1:0]  nxt_state;
reg  [12:0] rec_cnt_ff;
reg  [12:0] nxt_rec_cnt;
reg  [12:0] por_cnt_ff;
reg  [5:0]  pin_cnt_ff;
reg         ill_ff;
reg         wd_flag_ff;
reg         wr_pend_ff;
reg  [2:0]  wsel_ff;
reg  [31:0] rdata_ff;
reg  [31:0] nxt_rdata;

wire        addr_ok;
wire [2:0]  rsel;
wire [7:0]  opt1;
wire [7:0]  opt2;
wire [17:0] chain;
wire        wd_ovf;
wire        int_rst;
wire        supv_rst;
wire        pin_act;
wire        stop_en;
wire        stop_take;
wire        ill_take;
wire        wd_en;
wire        wd_run;
wire        por_clr;
wire        pre_clr;
wire        wr_opt1;
wire        wr_opt2;
wire        wr_svc;
wire        wr_stat;

// ------------------------------------------------
// bus slave: zero wait states, always okay
// ------------------------------------------------
assign addr_ok = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
assign rsel    = reg_sel(HADDR_IN);

always @* begin
    nxt_rdata = 32'h00000000;
    case (rsel)
        `WDOL_SEL_OPT2: begin
            nxt_rdata = {24'h000000, opt2};
        end
        `WDOL_SEL_OPT1: begin
            nxt_rdata = {24'h000000, opt1};
        end
        `WDOL_SEL_STAT: begin
            nxt_rdata = {18'h00000, chain[17:12], 5'h00,
                         (state_ff == ST_REC),
                         (state_ff == ST_STOP), wd_flag_ff};
        end
        `WDOL_SEL_SVC: begin
            nxt_rdata = {24'h000000, RESET_VEC_LO};
        end
        default: begin
            nxt_rdata = 32'h00000000;
        end
    endcase
end

// read data loaded at the address-phase edge, no side effect
always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
        wr_pend_ff <= 1'b0;
        wsel_ff    <= `WDOL_SEL_NONE;
        rdata_ff   <= 32'h00000000;
    end else begin
        wr_pend_ff <= addr_ok & HWRITE_IN;
        if (addr_ok) begin
            wsel_ff <= rsel;
        end
        if (addr_ok & ~HWRITE_IN) begin
            rdata_ff <= nxt_rdata;
        end
    end
end

assign HREADYOUT_OUT = 1'b1;
assign HRESP_OUT     = 1'b0;
assign HRDATA_OUT    = rdata_ff;

// writes act in the data phase; option writes held off while in reset
assign wr_opt2 = wr_pend_ff & (wsel_ff == `WDOL_SEL_OPT2) & ~int_rst;
assign wr_opt1 = wr_pend_ff & (wsel_ff == `WDOL_SEL_OPT1) & ~int_rst;
assign wr_stat = wr_pend_ff & (wsel_ff == `WDOL_SEL_STAT);
assign wr_svc  = wr_pend_ff & (wsel_ff == `WDOL_SEL_SVC);

// ------------------------------------------------
// option latches
// ------------------------------------------------
wdol_optlatch u_opt2 (
    .clk_in   (REF_CLK_IN),
    .por_in   (RST_IN),
    .clr_in   (int_rst),
    .wr_in    (wr_opt2),
    .wdata_in (HWDATA_IN[7:0]),
    .keep_in  (`WDOL_O2_KEEP),
    .q_out    (opt2)
);

wdol_optlatch u_opt1 (
    .clk_in   (REF_CLK_IN),
    .por_in   (RST_IN),
    .clr_in   (int_rst),
    .wr_in    (wr_opt1),
    .wdata_in (HWDATA_IN[7:0]),
    .keep_in  (`WDOL_O1_KEEP),
    .q_out    (opt1)
);

// ------------------------------------------------
// option-steered outputs
// ------------------------------------------------
assign OSC_RUN_OUT = (state_ff != ST_STOP) |
                     opt2[`WDOL_O2_OSC_STOP];
assign SERIAL_CLK_SEL_OUT = opt2[`WDOL_O2_BAUD_SEL];
assign SUPV_POWER_OUT = ~opt1[`WDOL_O1_SV_PWRD];
assign SUPV_ACTIVE_OUT = ~opt1[`WDOL_O1_SV_PWRD] &
                         ((state_ff != ST_STOP) |
                          opt1[`WDOL_O1_SV_STOP]);
assign SUPV_MODE5_OUT = opt1[`WDOL_O1_SV_MODE];
assign supv_rst = SUPV_RST_REQ_IN &
                  ~opt1[`WDOL_O1_SV_RSTD];

// ------------------------------------------------
// stop mode and recovery
// ------------------------------------------------
assign stop_en   = opt1[`WDOL_O1_STOP_EN];
assign stop_take = STOP_EXEC_IN & stop_en &
                   (state_ff == ST_RUN) & ~int_rst;
assign ill_take  = STOP_EXEC_IN & ~stop_en &
                   (state_ff == ST_RUN) & ~int_rst;

always @* begin
    nxt_state   = state_ff;
    nxt_rec_cnt = rec_cnt_ff;
    case (state_ff)
        ST_RUN: begin
            if (stop_take) begin
                nxt_state = ST_STOP;
            end
        end
        ST_STOP: begin
            if (PIN_WAKE_IN | int_rst) begin
                nxt_state   = ST_REC;
                nxt_rec_cnt = `WDOL_REC_LONG;
            end else if (WAKE_IN) begin
                nxt_state   = ST_REC;
                nxt_rec_cnt = opt1[`WDOL_O1_SHORT_STOP_RECOVERY] ?
                              `WDOL_REC_SHORT :
                              `WDOL_REC_LONG;
            end
        end
        ST_REC: begin
            // last count of the delay releases the core
            if (rec_cnt_ff <= 13'h0001) begin
                nxt_state   = ST_RUN;
                nxt_rec_cnt = 13'h0000;
            end else begin
                nxt_rec_cnt = rec_cnt_ff - 13'h0001;
            end
        end
        default: begin
            nxt_state   = ST_RUN;
            nxt_rec_cnt = 13'h0000;
        end
    endcase
end

always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
        state_ff   <= ST_RUN;
        rec_cnt_ff <= 13'h0000;
        ill_ff     <= 1'b0;
    end else begin
        state_ff   <= nxt_state;
        rec_cnt_ff <= nxt_rec_cnt;
        ill_ff     <= ill_take;
    end
end

assign STOP_MODE_OUT = (state_ff == ST_STOP);
assign CPU_HOLD_OUT  = (state_ff != ST_RUN);

// ------------------------------------------------
// power-up prescaler clear
// ------------------------------------------------
// counter parks at its end value so the clear fires once
always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
        por_cnt_ff <= 13'h0000;
    end else if (por_cnt_ff != `WDOL_REC_LONG) begin
        por_cnt_ff <= por_cnt_ff + 13'h0001;
    end
end

assign por_clr = (por_cnt_ff == `WDOL_POR_CLR_M1);

// ------------------------------------------------
// watchdog
// ------------------------------------------------
assign wd_en = ~opt1[`WDOL_O1_WD_DIS] &
               ~(MONITOR_IN & (HV_RST_IN | HV_IRQ_IN)) &
               ~(BREAK_IN & HV_RST_IN);
assign wd_run  = (state_ff != ST_STOP);
assign pre_clr = stop_take | VEC_FETCH_IN | por_clr;

// disabled watchdog is held clear so enabling starts a full period
wdol_wdog u_wdog (
    .clk_in     (REF_CLK_IN),
    .por_in     (RST_IN),
    .clr_in     (int_rst | ~wd_en),
    .pre_clr_in (pre_clr),
    .svc_in     (wr_svc),
    .run_in     (wd_run),
    .fast_in    (opt1[`WDOL_O1_RATE]),
    .ovf_out    (wd_ovf),
    .chain_out  (chain)
);

// ------------------------------------------------
// reset pin pulse and cause flag
// ------------------------------------------------
assign pin_act = (pin_cnt_ff != 6'h00);

always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
        pin_cnt_ff <= 6'h00;
        wd_flag_ff <= 1'b0;
    end else begin
        if (wd_ovf) begin
            pin_cnt_ff <= `WDOL_PIN_PULSE;
        end else if (pin_act) begin
            pin_cnt_ff <= pin_cnt_ff - 6'h01;
        end
        // a new overflow wins over a software clear
        if (wd_ovf) begin
            wd_flag_ff <= 1'b1;
        end else if (wr_stat & HWDATA_IN[`WDOL_ST_WD_FLAG]) begin
            wd_flag_ff <= 1'b0;
        end
    end
end

// internal reset: all sources except power-on
assign int_rst = EXT_RST_IN | supv_rst | ill_ff | pin_act;

assign SYS_RST_OUT      = RST_IN | int_rst;
assign RST_PIN_OUT      = 1'b0;
assign RST_PIN_OE_N_OUT = ~pin_act;

endmodule // wdol_top

// >>> core/wdol_wdog.v
`timescale 1ns/100ps
`include "wdol_regs.vh"

module wdol_wdog (
    // clock and resets
    input  wire        clk_in,
    input  wire        por_in,
    input  wire        clr_in,
    // control
    input  wire        pre_clr_in,
    input  wire        svc_in,
    input  wire        run_in,
    input  wire        fast_in,
    // status
    output wire        ovf_out,
    output wire [17:0] chain_out
);

// chain = {6-bit counter, 12-bit prescaler}
reg  [17:0] chain_ff;
reg  [17:0] nxt_chain;
wire [17:0] limit;

assign limit   = fast_in ? `WDOL_TMO_FAST_M1 : `WDOL_TMO_SLOW_M1;
assign ovf_out = run_in & (chain_ff == limit);

always @* begin
    nxt_chain = chain_ff;
    if (run_in) begin
        nxt_chain = chain_ff + 18'h00001;
    end
    if (ovf_out) begin
        nxt_chain = 18'h00000;
    end
    if (pre_clr_in) begin
        nxt_chain = {nxt_chain[17:12], 12'h000};
    end
    if (svc_in) begin
        nxt_chain = {14'h0000, nxt_chain[3:0]};
    end
end

always @(posedge clk_in or posedge por_in) begin
    if (por_in) begin
        chain_ff <= 18'h00000;
    end else if (clr_in) begin
        chain_ff <= 18'h00000;
    end else begin
        chain_ff <= nxt_chain;
    end
end

assign chain_out = chain_ff;

endmodule // wdol_wdog

// >>> include/wdol_regs.vh
`ifndef WDOL_REGS_VH
`define WDOL_REGS_VH

// ------------------------------------------------
// register indices (byte address = 4 * index)
// ------------------------------------------------
`define WDOL_IDX_OPT2      16'h001e
`define WDOL_IDX_OPT1      16'h001f
`define WDOL_IDX_STAT      16'h0020
`define WDOL_IDX_SVC       16'hffff

// ------------------------------------------------
// register select codes
// ------------------------------------------------
`define WDOL_SEL_NONE      3'h0
`define WDOL_SEL_OPT2      3'h1
`define WDOL_SEL_OPT1      3'h2
`define WDOL_SEL_STAT      3'h3
`define WDOL_SEL_SVC       3'h4

// ------------------------------------------------
// option_latch_two fields
// ------------------------------------------------
`define WDOL_O2_OSC_STOP   1
`define WDOL_O2_BAUD_SEL   0

// ------------------------------------------------
// option_latch_one fields
// ------------------------------------------------
`define WDOL_O1_RATE       7
`define WDOL_O1_SV_STOP    6
`define WDOL_O1_SV_RSTD    5
`define WDOL_O1_SV_PWRD    4
`define WDOL_O1_SV_MODE    3
`define WDOL_O1_SHORT_STOP_RECOVERY      2
`define WDOL_O1_STOP_EN    1
`define WDOL_O1_WD_DIS     0

// ------------------------------------------------
// reset values and power-on-only bits
// ------------------------------------------------
`define WDOL_OPT_RESET     8'h00
`define WDOL_O1_KEEP       8'h08
`define WDOL_O2_KEEP       8'h00

// ------------------------------------------------
// status register fields
// ------------------------------------------------
`define WDOL_ST_WD_FLAG    0

// ------------------------------------------------
// timing, in crystal-clock cycles
// ------------------------------------------------
`define WDOL_TMO_SLOW_M1   18'h3ffef
`define WDOL_TMO_FAST_M1   18'h01fef
`define WDOL_REC_SHORT     13'h0020
`define WDOL_REC_LONG      13'h1000
`define WDOL_POR_CLR_M1    13'h0fff
`define WDOL_PIN_PULSE     6'h20

`endif
